// File: rtl/panel_defines.svh
// timing constants and codes for the converter panel controller
`ifndef PANEL_DEFINES_SVH
`define PANEL_DEFINES_SVH
`define CLK_HZ 100000000
`define CONTACTOR_HOLD_MS 1000
`define KEY_SCAN_HZ 4
`define FLASH_HZ 2
`define STBY_DELAY_MIN_S 16'h0005
`define STBY_DELAY_MAX_S 16'h0384
`define STBY_DELAY_DEF_S 16'h0096
`define CHECK_CYCLES 16'h0010
`define CONTRAST_RESET 8'h80
`endif

// File: rtl/panel_pkg.sv
// shared types for the converter panel controller
package panel_pkg;
	typedef enum logic [1:0] {ST_CHECK, ST_ALARM, ST_STANDBY, ST_AVAIL} conv_state_t;
	typedef enum logic [2:0] {DM_DEFAULT, DM_VIEW, DM_ALARM, DM_BLACKBOX, DM_POWERLOG, DM_SETUP1, DM_SETUP2} disp_mode_t;
	typedef enum logic [2:0] {PIC_WAIT, PIC_STANDBY, PIC_OPERATION, PIC_NO_INTERLOCK, PIC_ESTOP, PIC_ALARM} status_pic_t;
	typedef struct packed {
		logic view_select_key;
		logic fault_view_key;
		logic settings_key;
		logic arrow_up;
		logic arrow_down;
	} keys_t;
	typedef struct packed {
		logic normal_led;
		logic alarm_led;
		logic settings_key_led;
	} mode_leds_t;
endpackage

// File: rtl/panel_sync.sv
// two-flop synchroniser for asynchronous panel inputs
`timescale 1ns/10ps
`default_nettype none
module panel_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage is read only by the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// File: rtl/panel_tick.sv
// free-running divider giving a one-cycle tick at a fixed period
`timescale 1ns/10ps
`default_nettype none
module panel_tick #(
	parameter int PERIOD = 100
) (
	input wire logic clk,
	input wire logic rst,
	output logic tick
);
	logic [31:0] cnt;

	// counter wraps at the period, tick on wrap
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 32'h00000000;
			tick <= 1'b0;
		end else if (cnt >= 32'(PERIOD - 1)) begin
			cnt <= 32'h00000000;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 32'h00000001;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: rtl/converter_panel_control.sv
// operating state, contactor, lamp and keyboard control for the converter panel
// What this block does
// - breaker on: check, standby only if clean
// - emergency stop drops all contactors at once
// - no restart while stopped; show stop picture
// - mains lamp when mains and breaker on
// - lamp test lights all button lamps
// - fault lights error lamp, enters alarm
// - standby start: test, engage, light button
// - contactor held one second ignoring interlock
// - lost interlock: standby after delay, shown
// - standby delay 5 to 900 s, default 150
// - available while any contactor engaged
// - available start engages that outlet, lit
// - every engaged outlet's interlock gone: standby after delay
// - stop releases own outlet only
// - both released: standby immediately
// - mode keys act on release, flash LED
// - arrow held keeps stepping the value
// - keyboard sampled four times per second
// - mode LEDs follow display mode table
// - below range shown as less-than minimum
// - contrast: view key held plus arrow
// - seven modes; default picks status picture
`timescale 1ns/10ps
`default_nettype none
`include "panel_defines.svh"
module converter_panel_control #(
	parameter int HOLD_CYCLES = (`CLK_HZ / 1000) * `CONTACTOR_HOLD_MS,
	parameter int SCAN_CYCLES = `CLK_HZ / `KEY_SCAN_HZ,
	parameter int FLASH_CYCLES = `CLK_HZ / (2 * `FLASH_HZ),
	parameter int SEC_CYCLES = `CLK_HZ,
	parameter int VAL_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic breaker_on,
	input wire logic mains_present,
	input wire logic estop,
	input wire logic lamp_test_fitted,
	input wire logic lamp_test_btn,
	input wire logic fault_internal,
	input wire logic fault_external,
	input wire logic [1:0] start_btn,
	input wire logic [1:0] stop_btn,
	input wire logic [1:0] interlock,
	input wire logic selftest_done,
	input wire logic selftest_ok,
	input wire logic [15:0] standby_delay_s,
	input wire panel_pkg::keys_t keys,
	input wire logic picture_shown,
	input wire logic [VAL_W-1:0] param_value,
	input wire logic [VAL_W-1:0] param_min,
	output logic [1:0] contactor,
	output logic [1:0] start_lamp,
	output logic mains_lamp,
	output logic error_lamp,
	output panel_pkg::conv_state_t conv_state,
	output panel_pkg::disp_mode_t disp_mode,
	output panel_pkg::status_pic_t status_pic,
	output panel_pkg::mode_leds_t mode_leds,
	output logic selftest_req,
	output logic [7:0] contrast,
	output logic setting_up,
	output logic setting_down,
	output logic pic_request,
	output logic below_range,
	output logic [VAL_W-1:0] shown_value
);
	// ----------------------------------------
	// input synchronisation
	// ----------------------------------------
	localparam int NSYNC = 17;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] s_in;
	logic s_breaker, s_mains, s_estop, s_ltest, s_fault_int, s_fault_ext, s_fault;
	logic [1:0] s_start, s_stop, s_ilk;
	panel_pkg::keys_t s_keys;
	assign raw_in = {breaker_on, mains_present, estop, lamp_test_btn, fault_internal, fault_external,
		start_btn, stop_btn, interlock, keys};
	panel_sync #(.W(NSYNC)) u_sync (.clk(clk), .rst(rst), .d(raw_in), .q(s_in));
	assign {s_breaker, s_mains, s_estop, s_ltest, s_fault_int, s_fault_ext, s_start, s_stop, s_ilk, s_keys} = s_in;
	// fault sources merged only after both are synchronised, so no gate sees a raw pin
	assign s_fault = s_fault_int | s_fault_ext;

	// ----------------------------------------
	// time bases
	// ----------------------------------------
	logic scan_tick, flash_tick, sec_tick;
	panel_tick #(.PERIOD(SCAN_CYCLES)) u_scan (.clk(clk), .rst(rst), .tick(scan_tick));
	panel_tick #(.PERIOD(FLASH_CYCLES)) u_flash (.clk(clk), .rst(rst), .tick(flash_tick));
	panel_tick #(.PERIOD(SEC_CYCLES)) u_sec (.clk(clk), .rst(rst), .tick(sec_tick));

	// clamp the configured delay into its legal span
	logic [15:0] delay_s;
	always_comb begin
		if (standby_delay_s < `STBY_DELAY_MIN_S)
			delay_s = `STBY_DELAY_MIN_S;
		else if (standby_delay_s > `STBY_DELAY_MAX_S)
			delay_s = `STBY_DELAY_MAX_S;
		else
			delay_s = standby_delay_s;
	end

	// ----------------------------------------
	// edge detection on panel buttons
	// ----------------------------------------
	logic [1:0] start_prev, stop_prev;
	logic [1:0] start_press, stop_press;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			start_prev <= 2'b00;
			stop_prev <= 2'b00;
		end else begin
			start_prev <= s_start;
			stop_prev <= s_stop;
		end
	end
	assign start_press = s_start & ~start_prev;
	assign stop_press = s_stop & ~stop_prev;

	// ----------------------------------------
	// operating state
	// ----------------------------------------
	logic [1:0] pending; // outlet awaiting self-test
	logic [31:0] hold_cnt;
	logic [15:0] delay_cnt;
	logic [15:0] check_cnt;
	logic ilk_lost;
	// standby delay counts while no engaged outlet has its interlock and the contactor hold has run out
	assign ilk_lost = ((contactor & s_ilk) == 2'b00) && hold_cnt == 32'h00000000;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_state <= panel_pkg::ST_CHECK;
			contactor <= 2'b00;
			pending <= 2'b00;
			selftest_req <= 1'b0;
			hold_cnt <= 32'h00000000;
			delay_cnt <= 16'h0000;
			check_cnt <= 16'h0000;
		end else if (!s_breaker) begin
			conv_state <= panel_pkg::ST_CHECK;
			contactor <= 2'b00;
			pending <= 2'b00;
			selftest_req <= 1'b0;
			hold_cnt <= 32'h00000000;
			check_cnt <= 16'h0000;
		end else if (s_estop) begin
			contactor <= 2'b00;
			pending <= 2'b00;
			selftest_req <= 1'b0;
			hold_cnt <= 32'h00000000;
			if (conv_state == panel_pkg::ST_AVAIL)
				conv_state <= panel_pkg::ST_STANDBY;
		end else if (s_fault) begin
			conv_state <= panel_pkg::ST_ALARM;
			contactor <= 2'b00;
			pending <= 2'b00;
			selftest_req <= 1'b0;
		end else begin
			if (hold_cnt != 32'h00000000)
				hold_cnt <= hold_cnt - 32'h00000001;
			unique case (conv_state)
				panel_pkg::ST_CHECK: begin
					// power-on check window, fault would divert to alarm above
					if (check_cnt >= `CHECK_CYCLES)
						conv_state <= panel_pkg::ST_STANDBY;
					else
						check_cnt <= check_cnt + 16'h0001;
				end
				panel_pkg::ST_ALARM: begin
					// reset from alarm only by start press once clean
					if (start_press != 2'b00)
						conv_state <= panel_pkg::ST_STANDBY;
				end
				panel_pkg::ST_STANDBY, panel_pkg::ST_AVAIL: begin
					if (pending == 2'b00 && start_press != 2'b00) begin
						pending <= start_press[0] ? 2'b01 : 2'b10;
						selftest_req <= 1'b1;
					end else if (pending != 2'b00 && selftest_done) begin
						selftest_req <= 1'b0;
						pending <= 2'b00;
						if (selftest_ok) begin
							contactor <= contactor | pending;
							conv_state <= panel_pkg::ST_AVAIL;
							hold_cnt <= 32'(HOLD_CYCLES);
							delay_cnt <= 16'h0000;
						end
					end
					if (conv_state == panel_pkg::ST_AVAIL) begin
						if ((contactor & ~stop_press) == 2'b00 && !(pending != 2'b00 && selftest_done && selftest_ok)) begin
							conv_state <= panel_pkg::ST_STANDBY;
							contactor <= 2'b00;
						end else if (!(pending != 2'b00 && selftest_done && selftest_ok))
							contactor <= contactor & ~stop_press;
						if (!ilk_lost)
							delay_cnt <= 16'h0000;
						else if (delay_cnt >= delay_s) begin
							conv_state <= panel_pkg::ST_STANDBY;
							contactor <= 2'b00;
						end else if (sec_tick)
							delay_cnt <= delay_cnt + 16'h0001;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// lamps
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mains_lamp <= 1'b0;
			error_lamp <= 1'b0;
			start_lamp <= 2'b00;
		end else begin
			mains_lamp <= s_mains & s_breaker;
			error_lamp <= s_fault;
			if (lamp_test_fitted && s_ltest)
				start_lamp <= 2'b11;
			else
				start_lamp <= contactor;
		end
	end

	// ----------------------------------------
	// keyboard scan, four samples per second
	// ----------------------------------------
	panel_pkg::keys_t ks, ks_prev;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ks <= '0;
			ks_prev <= '0;
		end else if (scan_tick) begin
			ks_prev <= ks;
			ks <= s_keys;
		end
	end

	// released keys, one pulse per scan
	logic rel_view, rel_fault, rel_set, rel_up, rel_down, arrows_held, contrast_mode;
	logic scan_d;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			scan_d <= 1'b0;
		else
			scan_d <= scan_tick;
	end
	assign rel_view = scan_d & ks_prev.view_select_key & ~ks.view_select_key;
	assign rel_fault = scan_d & ks_prev.fault_view_key & ~ks.fault_view_key;
	assign rel_set = scan_d & ks_prev.settings_key & ~ks.settings_key;
	assign rel_up = scan_d & ks_prev.arrow_up & ~ks.arrow_up;
	assign rel_down = scan_d & ks_prev.arrow_down & ~ks.arrow_down;
	assign arrows_held = ks.arrow_up | ks.arrow_down;
	assign contrast_mode = ks.view_select_key & arrows_held;

	// ----------------------------------------
	// display mode on release
	// ----------------------------------------
	logic mode_change;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			disp_mode <= panel_pkg::DM_DEFAULT;
			pic_request <= 1'b0;
		end else begin
			pic_request <= 1'b0;
			if (mode_change) begin
				pic_request <= 1'b1;
				if (rel_fault && ks.arrow_up)
					disp_mode <= panel_pkg::DM_BLACKBOX;
				else if (rel_fault && ks.arrow_down)
					disp_mode <= panel_pkg::DM_POWERLOG;
				else if (rel_fault)
					disp_mode <= panel_pkg::DM_ALARM;
				else if (rel_set)
					disp_mode <= (disp_mode == panel_pkg::DM_SETUP1) ? panel_pkg::DM_SETUP2 : panel_pkg::DM_SETUP1;
				else if (rel_view)
					disp_mode <= (disp_mode == panel_pkg::DM_VIEW) ? panel_pkg::DM_DEFAULT : panel_pkg::DM_VIEW;
				else if (disp_mode == panel_pkg::DM_DEFAULT)
					disp_mode <= panel_pkg::DM_VIEW;
			end
		end
	end
	// a view-key release that ended a contrast gesture is not a mode key
	logic contrast_seen;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			contrast_seen <= 1'b0;
		else if (contrast_mode)
			contrast_seen <= 1'b1;
		else if (!ks.view_select_key)
			contrast_seen <= 1'b0;
	end
	assign mode_change = (rel_view & ~contrast_seen) | rel_fault | rel_set |
		((rel_up | rel_down) & ~ks.view_select_key & ~contrast_seen &
		disp_mode != panel_pkg::DM_SETUP1 && disp_mode != panel_pkg::DM_SETUP2);

	// ----------------------------------------
	// contrast and setting stepping while held
	// ----------------------------------------
	logic editing;
	assign editing = disp_mode == panel_pkg::DM_SETUP1 || disp_mode == panel_pkg::DM_SETUP2;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			contrast <= `CONTRAST_RESET;
			setting_up <= 1'b0;
			setting_down <= 1'b0;
		end else begin
			setting_up <= 1'b0;
			setting_down <= 1'b0;
			if (scan_d && contrast_mode) begin
				if (ks.arrow_up && contrast != 8'hFF)
					contrast <= contrast + 8'h01;
				else if (ks.arrow_down && contrast != 8'h00)
					contrast <= contrast - 8'h01;
			end else if (scan_d && editing) begin
				setting_up <= ks.arrow_up;
				setting_down <= ks.arrow_down & ~ks.arrow_up;
			end
		end
	end

	// ----------------------------------------
	// mode LEDs and busy flashing
	// ----------------------------------------
	logic busy, flash;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			flash <= 1'b0;
		end else begin
			if (mode_change)
				busy <= 1'b1; // set wins over clear
			else if (picture_shown)
				busy <= 1'b0;
			if (flash_tick)
				flash <= ~flash;
		end
	end
	always_comb begin
		mode_leds = '0;
		unique case (disp_mode)
			panel_pkg::DM_DEFAULT, panel_pkg::DM_VIEW: mode_leds.normal_led = 1'b1;
			panel_pkg::DM_ALARM: mode_leds.alarm_led = 1'b1;
			panel_pkg::DM_BLACKBOX: begin
				mode_leds.alarm_led = 1'b1;
				mode_leds.normal_led = 1'b1;
			end
			panel_pkg::DM_POWERLOG: begin
				mode_leds.alarm_led = 1'b1;
				mode_leds.settings_key_led = 1'b1;
			end
			panel_pkg::DM_SETUP1: mode_leds.settings_key_led = 1'b1;
			panel_pkg::DM_SETUP2: mode_leds.settings_key_led = flash;
			default: mode_leds = '0;
		endcase
		if (busy)
			mode_leds.normal_led = flash;
	end

	// ----------------------------------------
	// status picture and value rendering
	// ----------------------------------------
	always_comb begin
		if (s_estop)
			status_pic = panel_pkg::PIC_ESTOP;
		else if (conv_state == panel_pkg::ST_ALARM)
			status_pic = panel_pkg::PIC_ALARM;
		else if (conv_state == panel_pkg::ST_CHECK)
			status_pic = panel_pkg::PIC_WAIT;
		else if (conv_state == panel_pkg::ST_AVAIL && ilk_lost)
			status_pic = panel_pkg::PIC_NO_INTERLOCK;
		else if (conv_state == panel_pkg::ST_AVAIL)
			status_pic = panel_pkg::PIC_OPERATION;
		else
			status_pic = panel_pkg::PIC_STANDBY;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			below_range <= 1'b0;
			shown_value <= '0;
		end else begin
			below_range <= param_value < param_min;
			shown_value <= (param_value < param_min) ? param_min : param_value;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_estop_drop;
		@(posedge clk) disable iff (rst) s_estop |=> contactor == 2'b00;
	endproperty
	a_estop_drop: assert property (p_estop_drop) else $error("contactor engaged under stop");
	property p_no_restart;
		@(posedge clk) disable iff (rst) s_estop |=> !$rose(contactor[0]) && !$rose(contactor[1]);
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("restart during stop");
	property p_mains;
		@(posedge clk) disable iff (rst) ##1 mains_lamp == $past(s_mains & s_breaker);
	endproperty
	a_mains: assert property (p_mains) else $error("mains lamp wrong");
	property p_ltest;
		@(posedge clk) disable iff (rst) (lamp_test_fitted && s_ltest) |=> start_lamp == 2'b11;
	endproperty
	a_ltest: assert property (p_ltest) else $error("lamp test not lit");
	property p_fault;
		@(posedge clk) disable iff (rst) (s_fault && s_breaker && !s_estop) |=> conv_state == panel_pkg::ST_ALARM && error_lamp;
	endproperty
	a_fault: assert property (p_fault) else $error("fault not alarmed");
	sequence s_engage;
		$rose(contactor[0]) || $rose(contactor[1]);
	endsequence
	property p_hold;
		@(posedge clk) disable iff (rst) s_engage |-> hold_cnt == 32'(HOLD_CYCLES) && conv_state == panel_pkg::ST_AVAIL;
	endproperty
	a_hold: assert property (p_hold) else $error("hold not started");
	property p_avail;
		@(posedge clk) disable iff (rst) (contactor != 2'b00) |-> conv_state == panel_pkg::ST_AVAIL;
	endproperty
	a_avail: assert property (p_avail) else $error("engaged but not available");
	property p_leds;
		@(posedge clk) disable iff (rst) (disp_mode == panel_pkg::DM_ALARM && !busy) |-> mode_leds == 3'b010;
	endproperty
	a_leds: assert property (p_leds) else $error("alarm led wrong");
	property p_range;
		@(posedge clk) disable iff (rst) (param_value < param_min) |=> below_range && shown_value == $past(param_min);
	endproperty
	a_range: assert property (p_range) else $error("range render wrong");
	property p_reset_open;
		@(posedge clk) disable iff (rst) (conv_state == panel_pkg::ST_CHECK) |-> contactor == 2'b00;
	endproperty
	a_reset_open: assert property (p_reset_open) else $error("contactor during check");
endmodule
`default_nettype wire

// File: tb/panel_operator.sv
// operator at the panel: buttons and display keys
`timescale 1ns/10ps
`default_nettype none
module panel_operator #(
	parameter int SCAN = 8
) (
	input wire logic clk,
	output panel_pkg::keys_t keys,
	output logic [1:0] start_btn,
	output logic [1:0] stop_btn
);
	// all contacts open at power on
	initial begin
		keys = '0;
		start_btn = 2'h0;
		stop_btn = 2'h0;
	end
	// short push, long enough to clear the two-flop sync
	task automatic tap(input logic is_stop, input int outlet);
		@(posedge clk);
		if (is_stop) stop_btn <= outlet[0] ? 2'h2 : 2'h1;
		else start_btn <= outlet[0] ? 2'h2 : 2'h1;
		repeat (4) @(posedge clk);
		stop_btn <= 2'h0;
		start_btn <= 2'h0;
		repeat (4) @(posedge clk);
	endtask
	// held over two scan periods so one tick surely sees it
	task automatic hold_key(input panel_pkg::keys_t k);
		@(posedge clk);
		keys <= k;
		repeat (2 * SCAN + 4) @(posedge clk);
	endtask
	task automatic release_key();
		keys <= '0;
		repeat (2 * SCAN + 4) @(posedge clk);
	endtask
	// view key goes down first and up last, else the arrow turns the page
	task automatic adjust(input logic up, input int scans);
		@(posedge clk);
		keys.view_select_key <= 1'b1;
		repeat (2 * SCAN) @(posedge clk);
		if (up) keys.arrow_up <= 1'b1;
		else keys.arrow_down <= 1'b1;
		repeat (scans * SCAN) @(posedge clk);
		keys.arrow_up <= 1'b0;
		keys.arrow_down <= 1'b0;
		repeat (2 * SCAN) @(posedge clk);
		keys.view_select_key <= 1'b0;
		repeat (2 * SCAN + 4) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the converter panel controller
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam int HOLD = 20;
	localparam int SCAN = 8;
	logic clk, rst, breaker_on, mains_present, estop, lamp_test_fitted, lamp_test_btn;
	logic fault_internal, fault_external, selftest_done, selftest_ok, picture_shown, test_pass;
	logic [1:0] start_btn, stop_btn, interlock, contactor, start_lamp;
	logic [15:0] standby_delay_s, param_value, param_min, shown_value;
	panel_pkg::keys_t keys;
	panel_pkg::conv_state_t conv_state;
	panel_pkg::disp_mode_t disp_mode;
	panel_pkg::status_pic_t status_pic;
	panel_pkg::mode_leds_t mode_leds;
	logic mains_lamp, error_lamp, selftest_req, setting_up, setting_down, pic_request, below_range;
	logic [7:0] contrast;
	logic seen_lo, seen_hi;
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	int n_up = 0;
	int n_dn = 0;
	int n_pic = 0;
	// short counts keep the run brief; expectations use the same values
	converter_panel_control #(.HOLD_CYCLES(HOLD), .SCAN_CYCLES(SCAN), .FLASH_CYCLES(4), .SEC_CYCLES(10)) i_dut (
		.clk(clk), .rst(rst), .breaker_on(breaker_on), .mains_present(mains_present), .estop(estop),
		.lamp_test_fitted(lamp_test_fitted), .lamp_test_btn(lamp_test_btn), .fault_internal(fault_internal),
		.fault_external(fault_external), .start_btn(start_btn), .stop_btn(stop_btn), .interlock(interlock),
		.selftest_done(selftest_done), .selftest_ok(selftest_ok), .standby_delay_s(standby_delay_s),
		.keys(keys), .picture_shown(picture_shown), .param_value(param_value), .param_min(param_min),
		.contactor(contactor), .start_lamp(start_lamp), .mains_lamp(mains_lamp), .error_lamp(error_lamp),
		.conv_state(conv_state), .disp_mode(disp_mode), .status_pic(status_pic), .mode_leds(mode_leds),
		.selftest_req(selftest_req), .contrast(contrast), .setting_up(setting_up),
		.setting_down(setting_down), .pic_request(pic_request), .below_range(below_range),
		.shown_value(shown_value)
	);
	panel_operator #(.SCAN(SCAN)) i_op (
		.clk(clk), .keys(keys), .start_btn(start_btn), .stop_btn(stop_btn)
	);
	// ---------------------------------------------
	// clock, test logic stand-in, watchdog
	// ---------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// test logic answers a request one cycle later
	always @(posedge clk) begin
		selftest_done <= selftest_req & ~selftest_done;
		selftest_ok <= test_pass;
	end
	// pulse counters for the one-cycle outputs
	always @(posedge clk) begin
		if (setting_up === 1'b1) n_up++;
		if (setting_down === 1'b1) n_dn++;
		if (pic_request === 1'b1) n_pic++;
	end
	// a hang counts as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// step past the edge so its updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic start_out(input int o);
		i_op.tap(1'b0, o);
		for (int i = 0; i < 20 && contactor[o] !== 1'b1; i++) cyc(1);
	endtask
	// ---------------------------------------------
	// test sequence
	// ---------------------------------------------
	initial begin
		rst = 1'b1;
		{breaker_on, mains_present, estop, lamp_test_fitted, lamp_test_btn} = 5'h00;
		{fault_internal, fault_external} = 2'h0;
		picture_shown = 1'b1;
		test_pass = 1'b1;
		interlock = 2'h3;
		standby_delay_s = 16'h0003;
		param_value = 16'h0003;
		param_min = 16'h000A;
		cyc(1);
		chk(contactor, 2'h0);
		chk(start_lamp, 2'h0);
		chk(contrast, 8'h80);
		@(posedge clk);
		rst <= 1'b0;
		breaker_on <= 1'b1;
		mains_present <= 1'b1;
		cyc(4);
		chk(mains_lamp, 1'b1);
		for (int i = 0; i < 60 && conv_state !== panel_pkg::ST_STANDBY; i++) cyc(1);
		chk(conv_state, panel_pkg::ST_STANDBY);
		chk(status_pic, panel_pkg::PIC_STANDBY);
		chk(mode_leds, 3'h4);
		$display("test power_on done");
		// two outlets up, then stopped one at a time
		start_out(0);
		chk(contactor, 2'h1);
		chk(conv_state, panel_pkg::ST_AVAIL);
		start_out(1);
		chk(contactor, 2'h3);
		chk(start_lamp, 2'h3);
		chk(status_pic, panel_pkg::PIC_OPERATION);
		i_op.tap(1'b1, 0);
		chk(contactor, 2'h2);
		i_op.tap(1'b1, 1);
		chk(contactor, 2'h0);
		chk(conv_state, panel_pkg::ST_STANDBY);
		$display("test outlets done");
		// plug absent: hold first, then the clamped five-second delay
		@(posedge clk);
		interlock <= 2'h0;
		start_out(0);
		chk(status_pic, panel_pkg::PIC_OPERATION);
		cyc(HOLD - 2);
		chk(contactor, 2'h1);
		cyc(8);
		chk(status_pic, panel_pkg::PIC_NO_INTERLOCK);
		cyc(17);
		chk(contactor, 2'h1);
		for (int i = 0; i < 60 && contactor !== 2'h0; i++) cyc(1);
		chk(contactor, 2'h0);
		chk(conv_state, panel_pkg::ST_STANDBY);
		$display("test interlock done");
		// emergency stop drops output and blocks restart
		@(posedge clk);
		interlock <= 2'h3;
		start_out(0);
		estop <= 1'b1;
		cyc(4);
		chk(contactor, 2'h0);
		i_op.tap(1'b0, 0);
		chk(contactor, 2'h0);
		chk(status_pic, panel_pkg::PIC_ESTOP);
		estop <= 1'b0;
		cyc(4);
		start_out(0);
		chk(contactor, 2'h1);
		$display("test estop done");
		// fault lamp follows the fault
		fault_external <= 1'b1;
		cyc(5);
		chk(error_lamp, 1'b1);
		chk(conv_state, panel_pkg::ST_ALARM);
		fault_external <= 1'b0;
		cyc(5);
		chk(error_lamp, 1'b0);
		fault_internal <= 1'b1;
		cyc(5);
		chk(error_lamp, 1'b1);
		fault_internal <= 1'b0;
		cyc(5);
		chk(conv_state, panel_pkg::ST_ALARM);
		// start press leaves alarm; a failed self-test keeps the outlet open
		i_op.tap(1'b0, 1);
		chk(conv_state, panel_pkg::ST_STANDBY);
		test_pass <= 1'b0;
		start_out(1);
		chk(contactor, 2'h0);
		test_pass <= 1'b1;
		lamp_test_fitted <= 1'b1;
		lamp_test_btn <= 1'b1;
		cyc(4);
		chk(start_lamp, 2'h3);
		lamp_test_btn <= 1'b0;
		cyc(4);
		chk(start_lamp, 2'h0);
		chk(below_range, 1'b1);
		chk(shown_value, 16'h000A);
		param_value <= 16'h0014;
		cyc(3);
		chk(below_range, 1'b0);
		chk(shown_value, 16'h0014);
		$display("test lamps done");
		// mode keys act on release; flash until picture shown
		picture_shown <= 1'b0;
		i_op.hold_key(5'h08);
		chk(disp_mode, panel_pkg::DM_DEFAULT);
		i_op.release_key();
		chk(disp_mode, panel_pkg::DM_ALARM);
		chk(mode_leds.alarm_led, 1'b1);
		i_op.hold_key(5'h04);
		i_op.release_key();
		chk(disp_mode, panel_pkg::DM_SETUP1);
		chk(mode_leds.settings_key_led, 1'b1);
		// arrows held in setup step the value once per scan
		i_op.hold_key(5'h02);
		i_op.release_key();
		i_op.hold_key(5'h01);
		i_op.release_key();
		chk(n_up >= 2 && n_up <= 3, 1'b1);
		chk(n_dn >= 2 && n_dn <= 3, 1'b1);
		chk(disp_mode, panel_pkg::DM_SETUP1);
		i_op.hold_key(5'h04);
		i_op.release_key();
		chk(disp_mode, panel_pkg::DM_SETUP2);
		i_op.hold_key(5'h10);
		i_op.release_key();
		chk(disp_mode, panel_pkg::DM_VIEW);
		chk(n_pic, 4);
		seen_lo = 1'b0;
		seen_hi = 1'b0;
		for (int i = 0; i < 12; i++) begin
			cyc(1);
			seen_lo |= (mode_leds.normal_led === 1'b0);
			seen_hi |= (mode_leds.normal_led === 1'b1);
		end
		chk({seen_lo, seen_hi}, 2'h3);
		picture_shown <= 1'b1;
		cyc(6);
		chk(mode_leds, 3'h4);
		$display("test keys done");
		// contrast steps once per scan while the arrow is held
		i_op.adjust(1'b1, 4);
		chk(contrast > 8'h80 && contrast <= 8'h86, 1'b1);
		chk(disp_mode, panel_pkg::DM_VIEW);
		i_op.adjust(1'b0, 8);
		chk(contrast < 8'h80 && contrast >= 8'h76, 1'b1);
		$display("test contrast done");
		conclude();
	end
endmodule
`default_nettype wire
